// ==== common/hss_map.svh ====
`ifndef HSS_MAP_SVH
`define HSS_MAP_SVH

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define HSS_FRAME_BITS      8
`define HSS_CNT_LAST        4'h7
`define HSS_CNT_OVER        4'h8
`define HSS_CNT_SAT         4'hf
`define HSS_WD_BIT          7
`define HSS_ADDR_MSB        6
`define HSS_ADDR_LSB        4
`define HSS_ADDR_OUTCTL     3'h0
`define HSS_ADDR_WDCFG      3'h1
`define HSS_ADDR_RDSEL      3'h2
`define HSS_OUT_ON_BIT      0
`define HSS_IN_MODE_MSB     2
`define HSS_IN_MODE_LSB     1
`define HSS_RDSEL_BIT       0

// ----------------------------------------------------------------------------
// Fault input positions
// ----------------------------------------------------------------------------
`define HSS_FLT_W           6
`define HSS_FLT_OPEN        0
`define HSS_FLT_RESIST      1
`define HSS_FLT_SEVERE      2
`define HSS_FLT_THERMAL     3
`define HSS_FLT_UNDERV      4
`define HSS_FLT_OVERV       5

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define HSS_RST_WD_SEL      2'h0
`define HSS_RST_RDSEL       1'h0
`define HSS_RST_OUT_ON      1'h0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define HSS_CLK_HZ          10000000
`define HSS_CYC_PER_MS      (`HSS_CLK_HZ / 1000)
`define HSS_WDTO0_MS        620
`define HSS_WDTO1_MS        310
`define HSS_WDTO2_MS        2500
`define HSS_WDTO3_MS        1250

`endif

// ==== common/hss_pkg.sv ====
package hss_pkg;

	typedef enum logic [2:0] {
		hss_sleep    = 3'b000,
		hss_normal   = 3'b001,
		hss_fault    = 3'b010,
		hss_failsafe = 3'b011,
		hss_limited  = 3'b100
	} hss_mode_e;

	typedef enum logic [1:0] {
		hss_in_off = 2'b00,
		hss_in_or  = 2'b01,
		hss_in_pwm = 2'b10
	} hss_in_mode_e;

	typedef enum logic [1:0] {
		hss_fsi_gnd = 2'b00,
		hss_fsi_off = 2'b01,
		hss_fsi_on  = 2'b10
	} hss_fsi_e;

endpackage

// ==== core/hss_sync.sv ====
`timescale 1ns/1ps

module hss_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] rst_val,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);

	logic [W-1:0] meta_ff;
	logic         rst_ff;

	// The reset value is caught by a clock edge, never loaded by the reset itself.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= '0;
			q_out   <= '0;
			rst_ff  <= 1'b1;
		end else if (rst_ff) begin
			meta_ff <= rst_val;
			q_out   <= rst_val;
			rst_ff  <= 1'b0;
		end else begin
			meta_ff <= d_in;
			q_out   <= meta_ff;
		end
	end

endmodule // hss_sync

// ==== core/hss_spi_ctrl.sv ====
`timescale 1ns/1ps
`include "hss_map.svh"

// What this block does
// - Frames are eight bits, most significant bit first.
// - SI is sampled on each rising SCLK edge into the shift register.
// - SO is released while chip select is high, driven only while low.
// - SO changes on each rising SCLK edge for the next falling edge.
// - Chip select low selects; traffic while high is ignored.
// - Reset low clears configuration and faults and selects sleep.
// - Release of reset starts the watchdog.
// - Wake high enables the watchdog.
// - Fault flag pulled low while any fault exists; details only on SO.
// - Grounded fail-safe select disables watchdog and fail-safe.
// - Watchdog timeout forces output per fail-safe select setting.
// - Loss of logic supply resets configuration, limited function remains.
// - Both supplies present gives normal mode.
// - Watchdog timeout moves the device to fail-safe mode.
// - Normal mode switches the load from serial commands.
// - Direct input drives output in a serially selected way.
// - A command lets a shared PWM on the direct input gate the load.
// - Diagnostics report open load, shorts, thermal and supply faults.
// - Fail-safe restores default configuration except the read select, load from parallel input.
// - Watchdog bit must toggle within timeout or fail-safe follows.
// - Watchdog timeout flag reads one while in fail-safe.
// - Faults are held, shifted out in the next valid frame with read select zero, then cleared.
// - Fault flag self-releases except latched overcurrent and undervoltage.

module hss_spi_ctrl
	import hss_pkg::*;
#(
	parameter int unsigned WD_MS_CYCLES = `HSS_CYC_PER_MS
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_b,
	input  wire logic                  sclk,
	input  wire logic                  cs_b,
	input  wire logic                  si,
	output logic                       so_out,
	output logic                       so_oe,
	input  wire logic                  wake_in,
	input  wire logic [1:0]            failsafe_select_input,
	input  wire logic                  direct_in,
	input  wire logic                  logic_supply_ok,
	input  wire logic                  power_supply,
	input  wire logic [`HSS_FLT_W-1:0] fault_cond_in,
	output logic                       switched_output,
	output logic                       fault_flag_n_out,
	output logic                       fault_flag_n_oe,
	output hss_mode_e                  mode_out
);

	// ------------------------------------------------------------------------
	// Link side, clocked by the master's SCLK
	// ------------------------------------------------------------------------
	logic       frm_rst_b;
	logic [7:0] rx_ff;
	logic [7:0] hold_ff;
	logic [3:0] cnt_ff;
	logic       so_ff;
	logic       done_tgl_ff;
	logic       over_tgl_ff;
	logic [7:0] stat_ff;

	// Chip select high holds the frame logic in reset, so stray clocks do nothing.
	assign frm_rst_b = rst_b & ~cs_b;

	always_ff @(posedge sclk or negedge rst_b) begin
		if (!rst_b) begin
			rx_ff <= 8'h00;
		end else begin
			rx_ff <= {rx_ff[6:0], si};
		end
	end

	always_ff @(posedge sclk or negedge frm_rst_b) begin
		if (!frm_rst_b) begin
			cnt_ff <= 4'h0;
		end else if (cnt_ff != `HSS_CNT_SAT) begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end

	// The eighth edge hands the command over; a ninth edge revokes it.
	always_ff @(posedge sclk or negedge rst_b) begin
		if (!rst_b) begin
			hold_ff     <= 8'h00;
			done_tgl_ff <= 1'b0;
			over_tgl_ff <= 1'b0;
		end else if (!cs_b && cnt_ff == `HSS_CNT_LAST) begin
			hold_ff     <= {rx_ff[6:0], si};
			done_tgl_ff <= ~done_tgl_ff;
		end else if (!cs_b && cnt_ff == `HSS_CNT_OVER) begin
			over_tgl_ff <= ~over_tgl_ff;
		end
	end

	// The status word is frozen by the system side while a frame is open.
	always_ff @(posedge sclk or negedge frm_rst_b) begin
		if (!frm_rst_b) begin
			so_ff <= 1'b0;
		end else if (cnt_ff < `HSS_CNT_LAST) begin
			so_ff <= stat_ff[3'h6 - cnt_ff[2:0]];
		end else begin
			so_ff <= 1'b0;
		end
	end

	assign so_out = (cnt_ff == 4'h0) ? stat_ff[7] : so_ff;
	assign so_oe  = ~cs_b;

	// ------------------------------------------------------------------------
	// Pin and link crossings into the system clock
	// ------------------------------------------------------------------------
	localparam int unsigned SW = 9 + `HSS_FLT_W;

	logic [SW-1:0]           sync_q;
	logic                    cs_s;
	logic                    done_s;
	logic                    over_s;
	logic                    wake_s;
	hss_fsi_e                fsi_s;
	logic                    din_s;
	logic                    lok_s;
	logic                    pok_s;
	logic [`HSS_FLT_W-1:0]   flt_s;

	hss_sync #(
		.W (SW)
	) u_sync (
		.clk     (sys_clk),
		.rst_b   (rst_b),
		.rst_val ({1'b1, done_tgl_ff, over_tgl_ff, {(SW-3){1'b0}}}),
		.d_in    ({cs_b, done_tgl_ff, over_tgl_ff, wake_in, failsafe_select_input,
		            direct_in, logic_supply_ok, power_supply, fault_cond_in}),
		.q_out   (sync_q)
	);

	assign cs_s   = sync_q[SW-1];
	assign done_s = sync_q[SW-2];
	assign over_s = sync_q[SW-3];
	assign wake_s = sync_q[SW-4];
	assign fsi_s  = hss_fsi_e'(sync_q[SW-5:SW-6]);
	assign din_s  = sync_q[SW-7];
	assign lok_s  = sync_q[SW-8];
	assign pok_s  = sync_q[SW-9];
	assign flt_s  = sync_q[`HSS_FLT_W-1:0];

	// ------------------------------------------------------------------------
	// Frame acceptance
	// ------------------------------------------------------------------------
	logic cs_d_ff;
	logic done_d_ff;
	logic over_d_ff;
	logic pend_ff;
	logic cs_rise;
	logic done_ev;
	logic over_ev;
	logic exec;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cs_d_ff   <= 1'b1;
			done_d_ff <= 1'b0;
			over_d_ff <= 1'b0;
		end else begin
			cs_d_ff   <= cs_s;
			done_d_ff <= done_s;
			over_d_ff <= over_s;
		end
	end

	assign cs_rise = cs_s & ~cs_d_ff;
	assign done_ev = done_s ^ done_d_ff;
	assign over_ev = over_s ^ over_d_ff;
	assign exec    = cs_rise & pend_ff & ~over_ev;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_ff <= 1'b0;
		end else if (over_ev || cs_rise) begin
			pend_ff <= 1'b0;
		end else if (done_ev) begin
			pend_ff <= 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// Configuration
	// ------------------------------------------------------------------------
	logic         failsafe_ff;
	logic         spi_on_ff;
	hss_in_mode_e in_mode_ff;
	logic [1:0]   wd_sel_ff;
	logic         rdsel_ff;
	logic [2:0]   cmd_addr;

	assign cmd_addr = hold_ff[`HSS_ADDR_MSB:`HSS_ADDR_LSB];

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			spi_on_ff  <= `HSS_RST_OUT_ON;
			in_mode_ff <= hss_in_off;
			wd_sel_ff  <= `HSS_RST_WD_SEL;
		end else if (!lok_s || failsafe_ff) begin
			spi_on_ff  <= `HSS_RST_OUT_ON;
			in_mode_ff <= hss_in_off;
			wd_sel_ff  <= `HSS_RST_WD_SEL;
		end else if (exec) begin
			unique case (cmd_addr)
				`HSS_ADDR_OUTCTL: begin
					spi_on_ff  <= hold_ff[`HSS_OUT_ON_BIT];
					in_mode_ff <= hss_in_mode_e'(hold_ff[`HSS_IN_MODE_MSB:`HSS_IN_MODE_LSB]);
				end
				`HSS_ADDR_WDCFG: begin
					wd_sel_ff <= hold_ff[1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// The read select survives fail-safe; only reset or loss of logic supply clears it.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdsel_ff <= `HSS_RST_RDSEL;
		end else if (!lok_s) begin
			rdsel_ff <= `HSS_RST_RDSEL;
		end else if (exec && cmd_addr == `HSS_ADDR_RDSEL) begin
			rdsel_ff <= hold_ff[`HSS_RDSEL_BIT];
		end
	end

	// ------------------------------------------------------------------------
	// Faults and status word
	// ------------------------------------------------------------------------
	logic [`HSS_FLT_W-1:0] flt_ff;
	logic [`HSS_FLT_W-1:0] flt_clr;
	logic                  flag_act;

	// Only the bits actually shifted out are cleared, and a new fault wins.
	assign flt_clr = (exec && !rdsel_ff) ? stat_ff[6:1] : '0;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			flt_ff <= '0;
		end else begin
			flt_ff <= (flt_ff & ~flt_clr) | flt_s;
		end
	end

	assign flag_act = (|flt_s) | flt_ff[`HSS_FLT_RESIST] | flt_ff[`HSS_FLT_SEVERE]
	                  | flt_ff[`HSS_FLT_UNDERV];

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			fault_flag_n_oe <= 1'b0;
		end else begin
			fault_flag_n_oe <= flag_act;
		end
	end

	assign fault_flag_n_out = 1'b0;

	// The word is only refreshed while the link is idle, so SCLK sees it stable.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_ff <= 8'h00;
		end else if (cs_s && cs_d_ff && !rdsel_ff) begin
			stat_ff <= {failsafe_ff, flt_ff, flag_act};
		end else if (cs_s && cs_d_ff) begin
			stat_ff <= {5'h00, failsafe_ff, wd_sel_ff};
		end
	end

	// ------------------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------------------
	logic        started_ff;
	logic        wd_last_ff;
	logic [31:0] wd_cnt_ff;
	logic        wd_on;
	logic        kick;
	logic        wd_to;

	function automatic logic [31:0] wd_limit(input logic [1:0] sel);
		logic [31:0] ms;
		unique case (sel)
			2'h0: ms = 32'(`HSS_WDTO0_MS);
			2'h1: ms = 32'(`HSS_WDTO1_MS);
			2'h2: ms = 32'(`HSS_WDTO2_MS);
			2'h3: ms = 32'(`HSS_WDTO3_MS);
		endcase
		return ms * 32'(WD_MS_CYCLES);
	endfunction

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			started_ff <= 1'b0;
		end else begin
			started_ff <= 1'b1;
		end
	end

	assign wd_on = (started_ff | wake_s) & (fsi_s != hss_fsi_gnd);
	assign kick  = exec & (hold_ff[`HSS_WD_BIT] != wd_last_ff);
	assign wd_to = wd_on & (wd_cnt_ff >= wd_limit(wd_sel_ff) - 32'h1);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_last_ff <= 1'b0;
		end else if (exec) begin
			wd_last_ff <= hold_ff[`HSS_WD_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_cnt_ff <= 32'h0;
		end else if (!wd_on || kick || failsafe_ff) begin
			wd_cnt_ff <= 32'h0;
		end else if (!wd_to) begin
			wd_cnt_ff <= wd_cnt_ff + 32'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			failsafe_ff <= 1'b0;
		end else if (fsi_s == hss_fsi_gnd) begin
			failsafe_ff <= 1'b0;
		end else if (wd_to) begin
			failsafe_ff <= 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// Mode and output drive
	// ------------------------------------------------------------------------
	logic nxt_out;

	always_comb begin
		if (!pok_s) begin
			mode_out = hss_sleep;
		end else if (failsafe_ff) begin
			mode_out = hss_failsafe;
		end else if (!lok_s) begin
			mode_out = hss_limited;
		end else if (flag_act) begin
			mode_out = hss_fault;
		end else begin
			mode_out = hss_normal;
		end
	end

	// Severe shorts and thermal shutdown keep the switch off in every mode.
	always_comb begin
		nxt_out = 1'b0;
		unique case (mode_out)
			hss_sleep: begin
				nxt_out = 1'b0;
			end
			hss_failsafe: begin
				nxt_out = (fsi_s == hss_fsi_on) | din_s;
			end
			hss_limited: begin
				nxt_out = din_s;
			end
			hss_normal, hss_fault: begin
				unique case (in_mode_ff)
					hss_in_or:  nxt_out = spi_on_ff | din_s;
					hss_in_pwm: nxt_out = spi_on_ff & din_s;
					default:    nxt_out = spi_on_ff;
				endcase
			end
			default: begin
				nxt_out = 1'b0;
			end
		endcase
		if (flt_s[`HSS_FLT_SEVERE] || flt_s[`HSS_FLT_THERMAL]) begin
			nxt_out = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			switched_output <= 1'b0;
		end else begin
			switched_output <= nxt_out;
		end
	end

endmodule // hss_spi_ctrl

// ==== sim/hss_spi_ctrl_checker.sv ====
`timescale 1ns/1ps
`include "hss_map.svh"

// ----------------------------------------
// Port checker
// ----------------------------------------
module hss_spi_ctrl_checker
	import hss_pkg::*;
(
	input wire logic                  sys_clk,
	input wire logic                  rst_b,
	input wire logic                  sclk,
	input wire logic                  cs_b,
	input wire logic                  si,
	input wire logic                  so_out,
	input wire logic                  so_oe,
	input wire logic                  wake_in,
	input wire logic [1:0]            failsafe_select_input,
	input wire logic                  direct_in,
	input wire logic                  logic_supply_ok,
	input wire logic                  power_supply,
	input wire logic [`HSS_FLT_W-1:0] fault_cond_in,
	input wire logic                  switched_output,
	input wire logic                  fault_flag_n_out,
	input wire logic                  fault_flag_n_oe,
	input wire hss_mode_e             mode_out
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	a_so_release: assert property (so_oe == !cs_b)
		else $error("serial output enable does not follow chip select");
	a_flag_open_drain: assert property (!fault_flag_n_out)
		else $error("fault flag data is not low");
	a_flag_follows: assert property ((|fault_cond_in) [*3] |-> ##[0:4] fault_flag_n_oe)
		else $error("fault flag not pulled low during fault");
	a_reset_clear: assert property ($rose(rst_b) |-> !switched_output && !fault_flag_n_oe)
		else $error("outputs not cleared by reset");
	a_limited_mode: assert property (!logic_supply_ok [*5] |-> mode_out == hss_limited)
		else $error("no limited mode without logic supply");
	a_fsi_ground: assert property ((failsafe_select_input == hss_fsi_gnd) [*5]
		|-> mode_out != hss_failsafe)
		else $error("fail-safe while select input grounded");
	a_failsafe_on: assert property ((mode_out == hss_failsafe
		&& failsafe_select_input == hss_fsi_on && !fault_flag_n_oe) [*4] |-> switched_output)
		else $error("fail-safe on setting does not drive load");
	a_normal_mode: assert property ((logic_supply_ok && power_supply && fault_cond_in == 0
		&& !fault_flag_n_oe && failsafe_select_input == hss_fsi_gnd) [*6] |-> mode_out == hss_normal)
		else $error("not in normal mode with both supplies");
endmodule // hss_spi_ctrl_checker

// ==== sim/hss_spi_master.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// Serial master model
// ----------------------------------------
module hss_spi_master (
	output logic      sclk,
	output logic      cs_b,
	output logic      si,
	input  wire logic so_out,
	input  wire logic so_oe
);
	initial begin
		sclk = 1'b0;
		cs_b = 1'b1;
		si   = 1'b0;
	end

	// The clock only runs inside a frame, so a phase offset keeps it unrelated to sys_clk.
	task automatic xfer(input logic [7:0] cmd, input int nbits, output logic [7:0] rx);
		logic so_line;
		rx = 8'h00;
		so_line = 1'b0;
		#1.7;
		cs_b = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			si = cmd[3'(7 - i)];
			#3;
			so_line = so_oe ? so_out : ~so_line;
			if (i < 8) rx[3'(7 - i)] = so_line;
			sclk = 1'b1;
			#3;
			sclk = 1'b0;
		end
		#400;
		cs_b = 1'b1;
		si = ~si;
		#500;
	endtask
endmodule // hss_spi_master

// ==== sim/high_side_switch_spi_control_tb_top.sv ====
`timescale 1ns/1ps
`include "hss_map.svh"

// ----------------------------------------
// Bench
// ----------------------------------------
module high_side_switch_spi_control_tb_top
	import hss_pkg::*;
;
	typedef struct {logic [7:0] cmd; logic din; logic exp;} hss_row_s;
	logic                  sys_clk, rst_b, sclk, cs_b, si, so_out, so_oe, wake_in, direct_in;
	logic                  logic_supply_ok, power_supply, switched_output;
	logic                  fault_flag_n_out, fault_flag_n_oe, wd_bit;
	logic [1:0]            failsafe_select_input;
	logic [`HSS_FLT_W-1:0] fault_cond_in;
	logic [7:0]            rx;
	hss_mode_e             mode_out;
	int                    bad_count, comparisons;
	hss_row_s rows [8] = '{'{8'h01, 1'b0, 1'b1}, '{8'h00, 1'b1, 1'b0}, '{8'h02, 1'b1, 1'b1},
		'{8'h02, 1'b0, 1'b0}, '{8'h05, 1'b1, 1'b1}, '{8'h05, 1'b0, 1'b0},
		'{8'h04, 1'b1, 1'b0}, '{8'h03, 1'b0, 1'b1}};

	hss_spi_ctrl #(.WD_MS_CYCLES(2)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .sclk(sclk),
		.cs_b(cs_b), .si(si), .so_out(so_out), .so_oe(so_oe), .wake_in(wake_in),
		.failsafe_select_input(failsafe_select_input), .direct_in(direct_in),
		.logic_supply_ok(logic_supply_ok), .power_supply(power_supply),
		.fault_cond_in(fault_cond_in), .switched_output(switched_output),
		.fault_flag_n_out(fault_flag_n_out), .fault_flag_n_oe(fault_flag_n_oe),
		.mode_out(mode_out));
	hss_spi_master u_master (.sclk(sclk), .cs_b(cs_b), .si(si), .so_out(so_out),
		.so_oe(so_oe));

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#10;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// The watchdog bit flips only on full frames, so short frames never feed it.
	task automatic frame(input logic [7:0] cmd, input int n);
		u_master.xfer({wd_bit, cmd[6:0]}, n, rx);
		if (n == 8) wd_bit = ~wd_bit;
		step(6);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d, bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		print_verdict();
	end

	initial begin
		bad_count = 0;
		comparisons = 0;
		wd_bit = 1'b1;
		rst_b <= 1'b0;
		logic_supply_ok <= 1'b1;
		power_supply <= 1'b1;
		wake_in <= 1'b0;
		direct_in <= 1'b0;
		fault_cond_in <= '0;
		failsafe_select_input <= hss_fsi_gnd;
		step(4);
		@(posedge sys_clk) rst_b <= 1'b1;
		step(4);
		check(8'(switched_output), 8'h00);
		check(8'(fault_flag_n_oe), 8'h00);
		check(8'(so_oe), 8'h00);
		foreach (rows[i]) begin
			@(posedge sys_clk) direct_in <= rows[i].din;
			frame(rows[i].cmd, 8);
			check(8'(switched_output), 8'(rows[i].exp));
		end
		frame(8'h00, 7);
		check(8'(switched_output), 8'h01);
		frame(8'h00, 9);
		check(8'(switched_output), 8'h01);
		frame(8'h00, 8);
		check(8'(switched_output), 8'h00);
		@(posedge sys_clk) fault_cond_in <= 6'h01;
		step(8);
		check(8'(fault_flag_n_oe), 8'h01);
		check(8'(mode_out), 8'(hss_fault));
		@(posedge sys_clk) fault_cond_in <= 6'h00;
		step(8);
		check(8'(fault_flag_n_oe), 8'h00);
		@(posedge sys_clk) fault_cond_in <= 6'h04;
		step(8);
		@(posedge sys_clk) fault_cond_in <= 6'h00;
		step(8);
		check(8'(fault_flag_n_oe), 8'h01);
		frame(8'h20, 8);
		check(rx, 8'h0b);
		check(8'(fault_flag_n_oe), 8'h00);
		frame(8'h20, 8);
		check(rx, 8'h00);
		@(posedge sys_clk) failsafe_select_input <= hss_fsi_on;
		wake_in <= 1'b1;
		step(4);
		frame(8'h11, 8);
		step(400);
		frame(8'h00, 8);
		step(500);
		check(8'(mode_out), 8'(hss_normal));
		step(200);
		check(8'(mode_out), 8'(hss_failsafe));
		check(8'(switched_output), 8'h01);
		frame(8'h21, 8);
		check(rx, 8'h80);
		frame(8'h20, 8);
		check(rx, 8'h04);
		check(8'(switched_output), 8'h01);
		@(posedge sys_clk) failsafe_select_input <= hss_fsi_off;
		frame(8'h01, 8);
		check(8'(switched_output), 8'h00);
		@(posedge sys_clk) failsafe_select_input <= hss_fsi_gnd;
		step(8);
		check(8'(mode_out), 8'(hss_normal));
		frame(8'h03, 8);
		@(posedge sys_clk) logic_supply_ok <= 1'b0;
		direct_in <= 1'b1;
		step(8);
		check(8'(mode_out), 8'(hss_limited));
		check(8'(switched_output), 8'h01);
		@(posedge sys_clk) logic_supply_ok <= 1'b1;
		step(8);
		check(8'(switched_output), 8'h00);
		frame(8'h01, 8);
		check(8'(switched_output), 8'h01);
		@(posedge sys_clk) rst_b <= 1'b0;
		wake_in <= 1'b0;
		failsafe_select_input <= hss_fsi_on;
		step(2);
		check(8'(switched_output), 8'h00);
		check(8'(mode_out), 8'(hss_sleep));
		@(posedge sys_clk) rst_b <= 1'b1;
		step(6);
		check(8'(switched_output), 8'h00);
		// With wake low only the reset release can have started the watchdog.
		step(1200);
		check(8'(mode_out), 8'(hss_normal));
		step(100);
		check(8'(mode_out), 8'(hss_failsafe));
		check(8'(switched_output), 8'h01);
		print_verdict();
	end
endmodule // high_side_switch_spi_control_tb_top

bind hss_spi_ctrl hss_spi_ctrl_checker u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .sclk(sclk),
	.cs_b(cs_b), .si(si), .so_out(so_out), .so_oe(so_oe), .wake_in(wake_in),
	.failsafe_select_input(failsafe_select_input), .direct_in(direct_in),
	.logic_supply_ok(logic_supply_ok), .power_supply(power_supply),
	.fault_cond_in(fault_cond_in), .switched_output(switched_output),
	.fault_flag_n_out(fault_flag_n_out), .fault_flag_n_oe(fault_flag_n_oe),
	.mode_out(mode_out));
